// *** hw/output_condition_detector.sv ***
// Output condition detector: decides when the two relay contacts and the
// photocoupler output close, from drive status and frequency/current samples.
// Assumes all status and sample inputs come from logic on pclk; settings arrive
// over APB.
`timescale 1ns/1ns
`default_nettype none

module output_condition_detector
	import output_condition_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TICK_CYCLES_DOC
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Samples, 0.1 Hz and 0.1 A units
	input  wire logic        sample_valid,
	input  wire logic [15:0] out_freq,
	input  wire logic [15:0] freq_ref,
	input  wire logic [15:0] out_current,
	// Drive status
	input  wire logic        accelerating,
	input  wire logic        decelerating,
	input  wire logic        freq_producing,
	input  wire logic        base_block,
	input  wire logic        traverse_rising,
	input  wire logic        traverse_accel,
	input  wire logic        traverse_wobble,
	input  wire logic        motor_two_selected,
	input  wire logic        pid_feedback_lost,
	input  wire logic        brake_release,
	input  wire logic        pid_sleeping,
	input  wire logic        short_brake_on,
	// Contacts
	output logic             relay_one_contact,
	output logic             relay_two_contact,
	output logic             photocoupler_output
);

	// ***************************************************************
	// Helpers
	// ***************************************************************
	function automatic logic hyst(input logic q, input logic set_c, input logic clr_c);
		return set_c ? 1'b1 : (clr_c ? 1'b0 : q);
	endfunction : hyst

	function automatic logic [15:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? 16'(a - b) : 16'(b - a);
	endfunction : abs_diff

	function automatic logic [16:0] level_plus(input logic [15:0] l, input logic [7:0] w);
		return {1'b0, l} + {9'h000, w};
	endfunction : level_plus

	function automatic logic [16:0] sat_inc(input logic [16:0] c);
		return (&c) ? c : 17'(c + 17'h00001);
	endfunction : sat_inc

	// ***************************************************************
	// Register file
	// ***************************************************************
	logic [5:0]  code_r1;
	logic [5:0]  code_r2;
	logic [5:0]  code_ph;
	logic        comm_contact_bit_one;
	logic        comm_contact_bit_two;
	logic [15:0] lvl1;
	logic [7:0]  wid1;
	logic [15:0] lvl2;
	logic [7:0]  wid2;
	logic [15:0] lvl3;
	logic [7:0]  wid3;
	logic [15:0] lvl4;
	logic [15:0] lvl5;
	logic [15:0] lvl6;
	logic [15:0] ca_level;
	logic [7:0]  ca_delay;
	logic [15:0] lc_level;
	logic [15:0] lc_delay;

	wire access   = psel & penable & ~pready;
	wire wr_en    = psel & penable & pready & pwrite;
	wire sel_func = paddr == OFF_FUNC_SEL;
	wire sel_comm = paddr == OFF_COMM;
	wire sel_d1   = paddr == OFF_DET_ONE;
	wire sel_d2   = paddr == OFF_DET_TWO;
	wire sel_d3   = paddr == OFF_DET_THREE;
	wire sel_rel  = paddr == OFF_REL_LVL;
	wire sel_l6   = paddr == OFF_LVL_SIX;
	wire sel_ca   = paddr == OFF_CUR_AGREE;
	wire sel_lc   = paddr == OFF_LOW_CUR;
	wire sel_st   = paddr == OFF_STATUS;
	wire hit      = sel_func | sel_comm | sel_d1 | sel_d2 | sel_d3 | sel_rel
	              | sel_l6 | sel_ca | sel_lc | sel_st;

	// Writes to the read-only status word are refused like unmapped ones
	wire refuse   = ~hit | (pwrite & sel_st);

	logic [31:0] status_word;
	wire [31:0] rd_word =
		sel_func ? {10'h000, code_ph, 2'h0, code_r2, 2'h0, code_r1} :
		sel_comm ? {30'h00000000, comm_contact_bit_two, comm_contact_bit_one} :
		sel_d1   ? {8'h00, wid1, lvl1} :
		sel_d2   ? {8'h00, wid2, lvl2} :
		sel_d3   ? {8'h00, wid3, lvl3} :
		sel_rel  ? {lvl5, lvl4} :
		sel_l6   ? {16'h0000, lvl6} :
		sel_ca   ? {8'h00, ca_delay, ca_level} :
		sel_lc   ? {lc_delay, lc_level} :
		sel_st   ? status_word : 32'h00000000;

	// One wait state: pready rises the cycle after the access phase opens
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			prdata  <= (access & ~pwrite) ? rd_word : 32'h00000000;
			pslverr <= access & refuse;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_r1 <= RST_FUNC;
			code_r2 <= RST_FUNC;
			code_ph <= RST_FUNC;
			comm_contact_bit_one <= 1'b0;
			comm_contact_bit_two <= 1'b0;
		end else if (wr_en && sel_func) begin
			code_r1 <= pwdata[POS_SEL_R1 +: 6];
			code_r2 <= pwdata[POS_SEL_R2 +: 6];
			code_ph <= pwdata[POS_SEL_PH +: 6];
		end else if (wr_en && sel_comm) begin
			comm_contact_bit_one <= pwdata[0];
			comm_contact_bit_two <= pwdata[1];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl1 <= RST_LEVEL;
			wid1 <= RST_WIDTH;
			lvl2 <= RST_LEVEL;
			wid2 <= RST_WIDTH;
			lvl3 <= RST_LEVEL;
			wid3 <= RST_WIDTH;
		end else if (wr_en) begin
			if (sel_d1) begin
				lvl1 <= pwdata[POS_LEVEL +: 16];
				wid1 <= pwdata[POS_WIDTH +: 8];
			end
			if (sel_d2) begin
				lvl2 <= pwdata[POS_LEVEL +: 16];
				wid2 <= pwdata[POS_WIDTH +: 8];
			end
			if (sel_d3) begin
				lvl3 <= pwdata[POS_LEVEL +: 16];
				wid3 <= pwdata[POS_WIDTH +: 8];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lvl4     <= RST_LEVEL;
			lvl5     <= RST_LEVEL;
			lvl6     <= RST_LEVEL;
			ca_level <= RST_LEVEL;
			ca_delay <= RST_CA_DLY;
			lc_level <= RST_LEVEL;
			lc_delay <= RST_LC_DLY;
		end else if (wr_en) begin
			if (sel_rel) begin
				lvl4 <= pwdata[POS_LEVEL +: 16];
				lvl5 <= pwdata[POS_HIGH_HALF +: 16];
			end
			if (sel_l6)
				lvl6 <= pwdata[POS_LEVEL +: 16];
			if (sel_ca) begin
				ca_level <= pwdata[POS_LEVEL +: 16];
				ca_delay <= pwdata[POS_WIDTH +: 8];
			end
			if (sel_lc) begin
				lc_level <= pwdata[POS_LEVEL +: 16];
				lc_delay <= pwdata[POS_HIGH_HALF +: 16];
			end
		end
	end

	// ***************************************************************
	// Control tick and registered samples
	// ***************************************************************
	logic [31:0] tick_cnt;
	logic        tick;
	logic        sample_ok;
	logic [15:0] freq_q;
	logic [15:0] ref_q;
	logic [15:0] cur_q;

	wire tick_wrap = tick_cnt >= 32'(TICK_CYCLES - 1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 32'h00000000;
			tick     <= 1'b0;
		end else begin
			tick_cnt <= tick_wrap ? 32'h00000000 : 32'(tick_cnt + 32'h00000001);
			tick     <= tick_wrap;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sample_ok <= 1'b0;
			freq_q    <= 16'h0000;
			ref_q     <= 16'h0000;
			cur_q     <= 16'h0000;
		end else if (sample_valid) begin
			sample_ok <= 1'b1;
			freq_q    <= out_freq;
			ref_q     <= freq_ref;
			cur_q     <= out_current;
		end
	end

	wire eval = tick & sample_ok;

	// ***************************************************************
	// Frequency comparators
	// ***************************************************************
	wire [16:0] f17  = {1'b0, freq_q};
	wire [16:0] thr1 = level_plus(lvl1, wid1);
	wire [16:0] thr2 = level_plus(lvl2, wid2);
	wire [16:0] thr3 = level_plus(lvl3, wid3);

	logic agree_q;
	logic set_agree_q;
	logic det1_q;
	logic det3_q;
	logic det4_q;
	logic det5_q;
	logic det6_q;
	logic crane_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			agree_q     <= 1'b0;
			set_agree_q <= 1'b0;
			det1_q      <= 1'b0;
			det3_q      <= 1'b0;
			det4_q      <= 1'b0;
			det5_q      <= 1'b0;
			det6_q      <= 1'b0;
			crane_q     <= 1'b0;
		end else if (eval) begin
			agree_q     <= abs_diff(freq_q, ref_q) <= {8'h00, wid1};
			set_agree_q <= abs_diff(freq_q, lvl1) <= {8'h00, wid1};
			det1_q      <= hyst(det1_q, f17 > thr1, freq_q < lvl1);
			det3_q      <= hyst(det3_q, f17 > thr2, freq_q < lvl2);
			det4_q      <= hyst(det4_q, freq_q < lvl5, f17 > thr2);
			det5_q      <= hyst(det5_q, f17 > thr3, freq_q < lvl6);
			det6_q      <= hyst(det6_q, freq_q < lvl6, f17 > thr3);
			crane_q     <= hyst(crane_q, accelerating & (f17 > thr1),
			                    decelerating & (freq_q < lvl4));
		end
	end

	// ***************************************************************
	// Current agree and low current, each with a fixed release delay
	// ***************************************************************
	logic        ca_on;
	logic [16:0] ca_cnt;
	logic [16:0] ca_rel;
	logic        lc_on;
	logic [16:0] lc_cnt;
	logic [16:0] lc_rel;

	wire        ca_cond   = cur_q > ca_level;
	wire [16:0] ca_target = 17'(17'(ca_delay) * CA_TICKS_PER_UNIT);
	wire        lc_enable = lc_level != 16'h0000;
	wire        lc_cond   = lc_enable & (cur_q <= lc_level);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ca_on  <= 1'b0;
			ca_cnt <= 17'h00000;
			ca_rel <= 17'h00000;
		end else if (eval) begin
			if (ca_cond) begin
				ca_rel <= 17'h00000;
				ca_cnt <= sat_inc(ca_cnt);
				if (sat_inc(ca_cnt) >= ca_target)
					ca_on <= 1'b1;
			end else begin
				ca_cnt <= 17'h00000;
				if (ca_on) begin
					ca_rel <= sat_inc(ca_rel);
					if (sat_inc(ca_rel) >= RELEASE_TICKS) begin
						ca_on  <= 1'b0;
						ca_rel <= 17'h00000;
					end
				end
			end
		end
	end

	// Disabling clears on the next control tick; the 100 ms hold applies only to a live condition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lc_on  <= 1'b0;
			lc_cnt <= 17'h00000;
			lc_rel <= 17'h00000;
		end else if (eval) begin
			if (!lc_enable) begin
				lc_on  <= 1'b0;
				lc_cnt <= 17'h00000;
				lc_rel <= 17'h00000;
			end else if (lc_cond) begin
				lc_rel <= 17'h00000;
				lc_cnt <= sat_inc(lc_cnt);
				if (sat_inc(lc_cnt) > {1'b0, lc_delay})
					lc_on <= 1'b1;
			end else begin
				lc_cnt <= 17'h00000;
				if (lc_on) begin
					lc_rel <= sat_inc(lc_rel);
					if (sat_inc(lc_rel) >= RELEASE_TICKS) begin
						lc_on  <= 1'b0;
						lc_rel <= 17'h00000;
					end
				end
			end
		end
	end

	// ***************************************************************
	// Function selection onto the contacts
	// ***************************************************************
	logic [63:0] fn_status;

	always_comb begin
		fn_status                 = 64'h0000000000000000;
		fn_status[FN_FREQ_AGREE]  = agree_q;
		fn_status[FN_SET_AGREE]   = set_agree_q;
		fn_status[FN_DET_ONE]     = det1_q;
		fn_status[FN_DET_TWO]     = sample_ok & ~det1_q;
		fn_status[FN_CUR_AGREE]   = ca_on;
		fn_status[FN_TRAV_UP]     = traverse_rising;
		fn_status[FN_TRAV_RUN]    = traverse_accel | traverse_wobble;
		fn_status[FN_MOTOR_TWO]   = motor_two_selected;
		fn_status[FN_FB_LOSS]     = pid_feedback_lost;
		fn_status[FN_BRAKE_REL]   = brake_release;
		fn_status[FN_CRANE]       = crane_q;
		fn_status[FN_PID_SLEEP]   = pid_sleeping;
		fn_status[FN_DET_THREE]   = det3_q;
		fn_status[FN_DET_FOUR]    = det4_q;
		fn_status[FN_DET_FIVE]    = det5_q;
		fn_status[FN_DET_SIX]     = det6_q;
		fn_status[FN_SHORT_BRAKE] = short_brake_on;
		fn_status[FN_LOW_CUR]     = lc_on;
		fn_status[FN_FREQ_OUT]    = freq_producing & ~base_block;
	end

	// Communication code maps bit one to relay one and bit two to the others
	wire next_r1 = (code_r1 == 6'(FN_COMM)) ? comm_contact_bit_one : fn_status[code_r1];
	wire next_r2 = (code_r2 == 6'(FN_COMM)) ? comm_contact_bit_two : fn_status[code_r2];
	wire next_ph = (code_ph == 6'(FN_COMM)) ? comm_contact_bit_two : fn_status[code_ph];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			relay_one_contact   <= 1'b0;
			relay_two_contact   <= 1'b0;
			photocoupler_output <= 1'b0;
		end else begin
			relay_one_contact   <= next_r1;
			relay_two_contact   <= next_r2;
			photocoupler_output <= next_ph;
		end
	end

	assign status_word = {13'h0000, photocoupler_output, relay_two_contact, relay_one_contact,
	                      6'h00, lc_on, ca_on, crane_q, det6_q, det5_q, det4_q,
	                      det3_q, det1_q, set_agree_q, agree_q};

endmodule : output_condition_detector

`default_nettype wire

// *** hw/output_condition_pkg.sv ***
// Constants for the output condition detector: register map, field
// positions, reset values, output function codes and timing figures.
// Assumes a 25 MHz pclk.
package output_condition_pkg;

	// ***************************************************************
	// Register offsets (byte addresses)
	// ***************************************************************
	localparam logic [7:0] OFF_FUNC_SEL  = 8'h00;
	localparam logic [7:0] OFF_COMM      = 8'h04;
	localparam logic [7:0] OFF_DET_ONE   = 8'h08;
	localparam logic [7:0] OFF_DET_TWO   = 8'h0C;
	localparam logic [7:0] OFF_DET_THREE = 8'h10;
	localparam logic [7:0] OFF_REL_LVL   = 8'h14;
	localparam logic [7:0] OFF_LVL_SIX   = 8'h18;
	localparam logic [7:0] OFF_CUR_AGREE = 8'h1C;
	localparam logic [7:0] OFF_LOW_CUR   = 8'h20;
	localparam logic [7:0] OFF_STATUS    = 8'h24;

	// ***************************************************************
	// Field positions
	// ***************************************************************
	localparam int POS_SEL_R1    = 0;
	localparam int POS_SEL_R2    = 8;
	localparam int POS_SEL_PH    = 16;
	localparam int POS_LEVEL     = 0;
	localparam int POS_WIDTH     = 16;
	localparam int POS_HIGH_HALF = 16;

	// ***************************************************************
	// Reset values
	// ***************************************************************
	localparam logic [5:0]  RST_FUNC   = 6'h00;
	localparam logic [15:0] RST_LEVEL  = 16'h0000;
	localparam logic [7:0]  RST_WIDTH  = 8'h14;
	localparam logic [7:0]  RST_CA_DLY = 8'h01;
	localparam logic [15:0] RST_LC_DLY = 16'h0000;

	// ***************************************************************
	// Output function codes
	// ***************************************************************
	localparam int FN_FREQ_AGREE  = 2;
	localparam int FN_SET_AGREE   = 3;
	localparam int FN_DET_ONE     = 4;
	localparam int FN_DET_TWO     = 5;
	localparam int FN_CUR_AGREE   = 13;
	localparam int FN_TRAV_UP     = 28;
	localparam int FN_TRAV_RUN    = 29;
	localparam int FN_MOTOR_TWO   = 30;
	localparam int FN_COMM        = 32;
	localparam int FN_FB_LOSS     = 37;
	localparam int FN_BRAKE_REL   = 38;
	localparam int FN_CRANE       = 39;
	localparam int FN_PID_SLEEP   = 45;
	localparam int FN_DET_THREE   = 50;
	localparam int FN_DET_FOUR    = 51;
	localparam int FN_DET_FIVE    = 52;
	localparam int FN_DET_SIX     = 53;
	localparam int FN_SHORT_BRAKE = 54;
	localparam int FN_LOW_CUR     = 57;
	localparam int FN_FREQ_OUT    = 58;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_HZ          = 25_000_000;
	localparam int TICK_MS         = 10;
	localparam int TICK_CYCLES_DOC = CLK_HZ / 1000 * TICK_MS;
	localparam int RELEASE_MS      = 100;
	localparam int CA_UNIT_MS      = 100;
	localparam logic [16:0] RELEASE_TICKS = 17'(RELEASE_MS / TICK_MS);
	localparam logic [16:0] CA_TICKS_PER_UNIT = 17'(CA_UNIT_MS / TICK_MS);

endpackage : output_condition_pkg

// *** verification/contact_model.sv ***
// Far-side model: two relay contacts and one photocoupler.
// Assumes a high drive closes a normally open contact.
`timescale 1ns/1ns
`default_nettype none
module contact_model (
	// Drives from the block
	input  wire logic       relay_one_contact,
	input  wire logic       relay_two_contact,
	input  wire logic       photocoupler_output,
	// Sensed state, photocoupler in bit 2
	output logic      [2:0] closed
);
	// Polarity selection lives elsewhere, so only open contacts are modelled
	assign closed = {photocoupler_output, relay_two_contact, relay_one_contact};
endmodule : contact_model
`default_nettype wire

// *** verification/output_condition_detector_tb.sv ***
// Bench for the output condition detector.
// Assumes package, design, checker and contact model compile first.
`timescale 1ns/1ns
`default_nettype none
module output_condition_detector_tb
	import output_condition_pkg::*;
;
	// *****
	// Bench
	// *****
	localparam int TK = 10;
	logic        pclk;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sample_valid = 1'b0;
	logic [15:0] out_freq = 16'h0;
	logic [15:0] freq_ref = 16'h0;
	logic [15:0] out_current = 16'h0;
	logic [11:0] st = 12'h0;
	logic        r1;
	logic        r2;
	logic        ph;
	logic [2:0]  closed;
	logic        look = 1'b0;
	logic        e;
	logic [32:0] q[$];
	logic [31:0] seed = 32'd87273;
	int          n_fail = 0;
	int          checked = 0;
	int          codes[8] = '{FN_TRAV_UP, FN_TRAV_RUN, FN_MOTOR_TWO, FN_FB_LOSS, FN_BRAKE_REL,
		FN_PID_SLEEP, FN_SHORT_BRAKE, FN_FREQ_OUT};
	// Rows: frequency, {decel, accel}, expected {photo, relay2, relay1}
	logic [20:0] det[11] = '{{16'h02BC, 2'h0, 3'h5}, {16'h0384, 2'h0, 3'h5},
		{16'h0406, 2'h0, 3'h2}, {16'h0384, 2'h0, 3'h2}, {16'h02BC, 2'h0, 3'h5},
		{16'h0276, 2'h1, 3'h3}, {16'h0226, 2'h2, 3'h6}, {16'h01C2, 2'h2, 3'h4},
		{16'h0276, 2'h0, 3'h1}, {16'h0406, 2'h0, 3'h1}, {16'h0262, 2'h0, 3'h6}};
	// Rows: current, expected early, expected late
	logic [21:0] cur[4] = '{{16'h00C8, 3'h0, 3'h1}, {16'h001E, 3'h3, 3'h2},
		{16'h00C8, 3'h2, 3'h1}, {16'h0000, 3'h1, 3'h0}};
	output_condition_detector #(.TICK_CYCLES(TK)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_valid(sample_valid), .out_freq(out_freq), .freq_ref(freq_ref),
		.out_current(out_current), .accelerating(st[0]), .decelerating(st[1]),
		.freq_producing(st[2]), .base_block(st[3]), .traverse_rising(st[4]),
		.traverse_accel(st[5]), .traverse_wobble(st[6]), .motor_two_selected(st[7]),
		.pid_feedback_lost(st[8]), .brake_release(st[9]), .pid_sleeping(st[10]),
		.short_brake_on(st[11]), .relay_one_contact(r1), .relay_two_contact(r2),
		.photocoupler_output(ph));
	contact_model far (.relay_one_contact(r1), .relay_two_contact(r2),
		.photocoupler_output(ph), .closed(closed));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [31:0] fsel(input int a, input int b, input int c);
		return {10'h0, 6'(c), 2'h0, 6'(b), 2'h0, 6'(a)};
	endfunction : fsel
	function automatic logic stat_exp(input int c, input logic [11:0] s);
		case (c)
			FN_TRAV_UP:     return s[4];
			FN_TRAV_RUN:    return s[5] | s[6];
			FN_MOTOR_TWO:   return s[7];
			FN_FB_LOSS:     return s[8];
			FN_BRAKE_REL:   return s[9];
			FN_PID_SLEEP:   return s[10];
			FN_SHORT_BRAKE: return s[11];
			default:        return s[2] & ~s[3];
		endcase
	endfunction : stat_exp
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp);
		int n;
		q.push_back(exp);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic look_at(input logic [2:0] exp);
		q.push_back({30'h0, exp});
		look <= 1'b1;
		@(posedge pclk);
		look <= 1'b0;
		@(posedge pclk);
	endtask : look_at
	task automatic final_report();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	// Results are taken off the note queue as they appear
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1)
			check({pslverr, prdata}, q.pop_front());
		else if (look)
			check({30'h0, closed}, q.pop_front());
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		look_at(3'h0);
		apb(1'b0, OFF_FUNC_SEL, 32'h0, 33'h0);
		apb(1'b0, OFF_STATUS, 32'h0, 33'h0);
		apb(1'b0, OFF_DET_ONE, 32'h0, {1'b0, 8'h00, RST_WIDTH, RST_LEVEL});
		apb(1'b0, OFF_CUR_AGREE, 32'h0, {1'b0, 8'h00, RST_CA_DLY, 16'h0000});
		apb(1'b0, 8'h28, 32'h0, {1'b1, 32'h0});
		apb(1'b1, OFF_STATUS, 32'h0000_FFFF, {1'b1, 32'h0});
		apb(1'b1, OFF_DET_TWO, 32'h0014_03E8, 33'h0);
		apb(1'b0, OFF_DET_TWO, 32'h0, 33'h0_0014_03E8);
		sample_valid <= 1'b1;
		freq_ref     <= 16'(rnd() >> 16);
		foreach (codes[i]) begin
			apb(1'b1, OFF_FUNC_SEL, fsel(codes[i], codes[i], codes[i]), 33'h0);
			repeat (4) begin
				st <= 12'(rnd());
				@(posedge pclk);
				e = stat_exp(codes[i], st);
				look_at({3{e}});
			end
		end
		apb(1'b1, OFF_FUNC_SEL, fsel(FN_COMM, FN_COMM, FN_COMM), 33'h0);
		for (int v = 0; v < 4; v++) begin
			apb(1'b1, OFF_COMM, 32'(v), 33'h0);
			look_at({v[1], v[1], v[0]});
		end
		presetn <= 1'b0;
		look_at(3'h0);
		presetn <= 1'b1;
		apb(1'b0, OFF_FUNC_SEL, 32'h0, 33'h0);
		apb(1'b1, OFF_DET_ONE, 32'h0014_0258, 33'h0);
		apb(1'b1, OFF_DET_TWO, 32'h0014_03E8, 33'h0);
		apb(1'b1, OFF_DET_THREE, 32'h0014_03E8, 33'h0);
		apb(1'b1, OFF_REL_LVL, 32'h0320_01F4, 33'h0);
		apb(1'b1, OFF_LVL_SIX, 32'h0000_0320, 33'h0);
		foreach (det[i]) begin
			if (i == 0) apb(1'b1, OFF_FUNC_SEL, fsel(FN_DET_FOUR, FN_DET_FIVE, FN_DET_SIX), 33'h0);
			if (i == 5) apb(1'b1, OFF_FUNC_SEL, fsel(FN_DET_ONE, FN_CRANE, FN_DET_TWO), 33'h0);
			// Reference pinned so the agree result follows from the rows alone
			if (i == 9) begin
				apb(1'b1, OFF_FUNC_SEL, fsel(FN_DET_THREE, FN_SET_AGREE, FN_FREQ_AGREE), 33'h0);
				freq_ref <= 16'h0262;
			end
			out_freq <= det[i][20:5];
			st       <= {10'h0, det[i][4:3]};
			repeat (3 * TK) @(posedge pclk);
			look_at(det[i][2:0]);
		end
		apb(1'b1, OFF_CUR_AGREE, 32'h0001_0064, 33'h0);
		apb(1'b1, OFF_LOW_CUR, 32'h0003_0032, 33'h0);
		apb(1'b1, OFF_FUNC_SEL, fsel(FN_CUR_AGREE, FN_LOW_CUR, 0), 33'h0);
		foreach (cur[i]) begin
			if (i == 3) apb(1'b1, OFF_LOW_CUR, 32'h0003_0000, 33'h0);
			out_current <= cur[i][21:6];
			repeat (8 * TK) @(posedge pclk);
			look_at(cur[i][5:3]);
			repeat (3 * TK) @(posedge pclk);
			look_at(cur[i][2:0]);
		end
		final_report();
	end
endmodule : output_condition_detector_tb
bind output_condition_detector output_condition_properties chk (.*);
`default_nettype wire

// *** verification/output_condition_properties.sv ***
// Contact checker for the output condition detector.
// Bound to the top module; mirrors the selection word from APB writes.
`timescale 1ns/1ns
`default_nettype none
module output_condition_properties
	import output_condition_pkg::*;
(
	// Clock and bus
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	// Status
	input wire logic        freq_producing,
	input wire logic        base_block,
	input wire logic        traverse_rising,
	input wire logic        traverse_accel,
	input wire logic        traverse_wobble,
	input wire logic        motor_two_selected,
	input wire logic        pid_feedback_lost,
	input wire logic        brake_release,
	input wire logic        pid_sleeping,
	input wire logic        short_brake_on,
	// Contacts
	input wire logic        relay_one_contact,
	input wire logic        relay_two_contact,
	input wire logic        photocoupler_output
);
	// ****************
	// Selection mirror
	// ****************
	logic [21:0] fs;
	logic [21:0] fs_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fs   <= '0;
			fs_d <= '0;
		end else begin
			fs_d <= fs;
			if (psel && penable && pready && pwrite && paddr == OFF_FUNC_SEL)
				fs <= pwdata[21:0];
		end
	end
	// **********
	// Properties
	// **********
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// A code must have settled for two edges before the contact follows it
	sequence s_held(int sh, int c);
		fs[sh+:6] == c && fs_d[sh+:6] == c;
	endsequence
	property p_trav_up;
		s_held(POS_SEL_R1, FN_TRAV_UP) |-> relay_one_contact == $past(traverse_rising);
	endproperty
	a_trav_up: assert property (p_trav_up) else $error("bad traverse up");
	property p_trav_run;
		s_held(POS_SEL_R2, FN_TRAV_RUN)
			|-> relay_two_contact == $past(traverse_accel || traverse_wobble);
	endproperty
	a_trav_run: assert property (p_trav_run) else $error("bad traverse run");
	property p_motor_two;
		s_held(POS_SEL_PH, FN_MOTOR_TWO) |-> photocoupler_output == $past(motor_two_selected);
	endproperty
	a_motor_two: assert property (p_motor_two) else $error("bad motor two");
	property p_fb_loss;
		s_held(POS_SEL_R1, FN_FB_LOSS) |-> relay_one_contact == $past(pid_feedback_lost);
	endproperty
	a_fb_loss: assert property (p_fb_loss) else $error("bad feedback loss");
	property p_brake_rel;
		s_held(POS_SEL_R2, FN_BRAKE_REL) |-> relay_two_contact == $past(brake_release);
	endproperty
	a_brake_rel: assert property (p_brake_rel) else $error("bad brake release");
	property p_sleep;
		s_held(POS_SEL_PH, FN_PID_SLEEP) |-> photocoupler_output == $past(pid_sleeping);
	endproperty
	a_sleep: assert property (p_sleep) else $error("bad sleep");
	property p_short_brake;
		s_held(POS_SEL_R1, FN_SHORT_BRAKE) |-> relay_one_contact == $past(short_brake_on);
	endproperty
	a_short_brake: assert property (p_short_brake) else $error("bad short brake");
	property p_freq_out;
		s_held(POS_SEL_PH, FN_FREQ_OUT)
			|-> photocoupler_output == $past(freq_producing && !base_block);
	endproperty
	a_freq_out: assert property (p_freq_out) else $error("bad freq output");
	property p_reset_open;
		$rose(presetn) |-> !relay_one_contact && !relay_two_contact && !photocoupler_output;
	endproperty
	a_reset_open: assert property (p_reset_open) else $error("contact after reset");
endmodule : output_condition_properties
`default_nettype wire
